// [tb/reset_controller_tb.sv]
// Purpose: Register-level tests of the reset controller
// Assumes: 50 MHz aclk, AXI4-Lite master tasks, line model on the pin
// Notes: Drive length field L gives 2^(L+1) low cycles
`timescale 1ns/1ps
module reset_controller_tb;
    import reset_ctrl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, periph_reset_req = 1'b0, press = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, rr;
    logic awready, wready, bvalid, arready, rvalid, pin_in, pin_out, pin_oe;
    logic proc_resetn, periph_resetn, irq;
    int bad_count = 0, n_tests = 0, cnt;

    // Clock and watchdog
    always #10 aclk = ~aclk;
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end

    reset_controller i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .periph_reset_req, .pin_in, .pin_out, .pin_oe,
        .proc_resetn, .periph_resetn, .irq);
    reset_line_model i_line (.pin_oe, .pin_out, .press, .pin_in);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h want %h", $time, g, e);
            bad_count++;
        end
    endtask

    // Write with both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && (awready === 1'b1);
            tw = pw && (wready === 1'b1);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        @(negedge aclk);
        while (bvalid !== 1'b1) @(negedge aclk);
        chk(bresp, er);
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    // Read one word, response code kept in rr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge aclk);
        while (arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (rvalid !== 1'b1) @(negedge aclk);
        d = rdata;
        rr = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic wait_lvl(ref logic s, input logic v);
        @(negedge aclk);
        while (s !== v) @(negedge aclk);
    endtask

    // Length of one pin drive in cycles
    task automatic oe_len(output int c);
        wait_lvl(pin_oe, 1'b1);
        c = 0;
        while (pin_oe === 1'b1) begin
            c++;
            @(negedge aclk);
        end
    endtask

    // Count cycles with processor reset asserted over a span
    task automatic quiet(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(negedge aclk);
            if (proc_resetn !== 1'b1) k++;
        end
    endtask

    task automatic set_press(input logic v);
        @(posedge aclk);
        press <= v;
    endtask

    // Test sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(MODE_OFFSET, rv);
        chk(rv, 32'h0000_0001);
        rd(STATUS_OFFSET, rv);
        chk(rv, 32'h0001_0000);
        rd(8'h14, rv);
        chk({rr, rv}, {RESP_SLVERR, 32'h0});
        wr(8'h14, 32'h0, RESP_SLVERR);
        wr(MODE_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        rd(MODE_OFFSET, rv);
        chk(rv, 32'h0000_0F11);
        wr(MODE_OFFSET, 32'h0000_0001, RESP_OKAY);
        $display("test registers done");
        @(posedge aclk);
        periph_reset_req <= 1'b1;
        @(posedge aclk);
        periph_reset_req <= 1'b0;
        wait_lvl(proc_resetn, 1'b0);
        chk(periph_resetn, 1'b0);
        oe_len(cnt);
        chk(cnt, 32'h2);
        wait_lvl(proc_resetn, 1'b1);
        rd(MODE_OFFSET, rv);
        chk(rv, 32'h0000_0001);
        wr(STATUS_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        rd(STATUS_OFFSET, rv);
        chk({rv[9:8], rv[0]}, {CAUSE_PERIPH, 1'b1});
        rd(STATUS_OFFSET, rv);
        chk(rv[0], 1'b0);
        rd(IRQ_STATUS_OFFSET, rv);
        chk(rv, 32'h0000_0002);
        wr(IRQ_STATUS_OFFSET, 32'h0000_0002, RESP_OKAY);
        rd(IRQ_STATUS_OFFSET, rv);
        chk(rv, 32'h0);
        $display("test peripheral done");
        set_press(1'b1);
        wait_lvl(proc_resetn, 1'b0);
        chk({periph_resetn, pin_oe}, 2'h0);
        set_press(1'b0);
        wait_lvl(proc_resetn, 1'b1);
        rd(STATUS_OFFSET, rv);
        chk({rv[9:8], rv[0]}, {CAUSE_USER, 1'b1});
        $display("test user pin done");
        wr(MODE_OFFSET, 32'h0, RESP_OKAY);
        set_press(1'b1);
        quiet(12, cnt);
        chk(cnt, 32'h0);
        rd(STATUS_OFFSET, rv);
        chk({rv[16], rv[0]}, 2'h1);
        set_press(1'b0);
        quiet(8, cnt);
        rd(STATUS_OFFSET, rv);
        chk({rv[16], rv[0]}, 2'h2);
        $display("test disabled done");
        wr(IRQ_MASK_OFFSET, 32'h0, RESP_OKAY);
        wr(MODE_OFFSET, 32'h0000_0011, RESP_OKAY);
        set_press(1'b1);
        quiet(10, cnt);
        chk(cnt, 32'h0);
        set_press(1'b0);
        quiet(8, cnt);
        chk({cnt, irq}, 33'h0);
        rd(IRQ_STATUS_OFFSET, rv);
        chk(rv, 32'h0000_0001);
        wr(IRQ_MASK_OFFSET, 32'h0000_0001, RESP_OKAY);
        chk(irq, 1'b1);
        wr(IRQ_STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
        chk(irq, 1'b0);
        $display("test interrupt done");
        wr(MODE_OFFSET, 32'h0000_0101, RESP_OKAY);
        wr(CTRL_OFFSET, 32'h0000_0008, RESP_OKAY);
        oe_len(cnt);
        chk({cnt, proc_resetn}, {32'h4, 1'b1});
        // Let the pin read high again so the state manager is idle for the next request
        repeat (12) @(posedge aclk);
        wr(CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
        wait_lvl(proc_resetn, 1'b0);
        chk(periph_resetn, 1'b1);
        wait_lvl(proc_resetn, 1'b1);
        rd(STATUS_OFFSET, rv);
        chk(rv[9:8], CAUSE_SOFT);
        rd(CTRL_OFFSET, rv);
        chk(rv, 32'h0);
        $display("test software done");
        end_of_test();
    end
endmodule // reset_controller_tb

// [tb/reset_line_model.sv]
// Purpose: External reset line with pull-up, push-button and the block's open drain
// Assumes: Button and block only ever pull the line low
// Notes: Released line returns to the pull-up level, never holds a stale value
`timescale 1ns/1ps
module reset_line_model (
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic press,
    output logic pin_in
);
    // Wired-AND of all pull-down sources over the pull-up
    assign pin_in = ((pin_oe && !pin_out) || press) ? 1'b0 : 1'b1;
endmodule // reset_line_model

// [verilog/axil_port.sv]
// Purpose: AXI4-Lite slave front end turning bus beats into strobes
// Assumes: One write and one read outstanding at most
// Notes: Write strobe in the first cycle both halves are held
`timescale 1ns/1ps
module axil_port
    import reset_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic rd_en,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // Handshake terms
    assign awready = !aw_full_reg && !bvalid_reg;
    assign wready = !w_full_reg && !bvalid_reg;
    assign wr_en = aw_full_reg && w_full_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign rd_en = arvalid && !rvalid_reg;
    assign rd_addr = araddr;

    // Write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_en) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (rd_en) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_hit ? rd_data : 32'h0000_0000;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
endmodule // axil_port

// [verilog/pin_manager.sv]
// Purpose: Samples the reset pin and drives it low on request
// Assumes: Pin is asynchronous to aclk
// Notes: Drive length is 2^(len+1) clock cycles
`timescale 1ns/1ps
module pin_manager
    import reset_ctrl_pkg::*;
#(
    parameter int LEN_WIDTH = LEN_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    input wire logic drive_req,
    input wire logic [LEN_WIDTH-1:0] len,
    output logic pin_level,
    output logic pin_fall,
    output logic pin_out,
    output logic pin_oe,
    output logic busy
);
    localparam int CNT_W = (1 << LEN_WIDTH) + 1;

    initial begin
        if (LEN_WIDTH < 1 || LEN_WIDTH > 5) $error("LEN_WIDTH out of range");
    end

    function automatic logic [CNT_W-1:0] pulse_len(input logic [LEN_WIDTH-1:0] l);
        // Widen before adding one so the longest setting does not wrap to zero
        pulse_len = CNT_W'(1) << ({1'b0, l} + {{LEN_WIDTH{1'b0}}, 1'b1});
    endfunction

    logic s1_reg, s2_reg, s3_reg, level_reg, fall_reg, busy_reg;
    logic [CNT_W-1:0] cnt_reg;
    wire agree = (s2_reg == s3_reg);

    // Sample pin every cycle, level changes when stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level_reg <= 1'b1;
            fall_reg <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                level_reg <= s3_reg;
            end
            fall_reg <= agree && !s3_reg && level_reg;
        end
    end

    // Drive counter, loaded at a request while not busy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (drive_req && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= pulse_len(len);
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == CNT_W'(1)) begin
                busy_reg <= 1'b0;
            end
        end
    end

    assign pin_level = level_reg;
    assign pin_fall = fall_reg;
    assign pin_out = 1'b0;
    assign pin_oe = busy_reg;
    assign busy = busy_reg;
endmodule // pin_manager

// [verilog/reset_controller.sv]
// Purpose: Reset state manager with reset pin manager and registers
// Assumes: aclk is the slow clock; aresetn is the io supply power-on reset
// Notes: Reset outputs never reset this block itself
// Operation
// - Whole controller runs on slow clock only
// - Active-low processor reset, also resets watchdog
// - Active-low reset for all peripherals
// - Resets from peripherals, pin or software
// - State manager picks resets, requests pin drive
// - Pin driven low for programmable time
// - Mode register survives core resets
// - Reset pin sampled every slow clock cycle
// - Low pin sample reports a user reset
// - Enable bit cleared stops pin-triggered resets
// - Status bit shows current pin level
// - Sticky flag set when pin seen asserted
// - Sticky flag cleared only by status read
// - Interrupt enable turns pin reset into interrupt
`timescale 1ns/1ps
module reset_controller
    import reset_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic periph_reset_req,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic proc_resetn,
    output logic periph_resetn,
    output logic irq
);
    // Merge write data into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    logic wr_en, rd_en, wr_hit, rd_hit;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic pin_level, pin_fall, pin_busy;

    logic [31:0] mode_reg, mode_next;
    logic seen_reg, seen_next;
    logic [1:0] cause_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg;
    logic [31:0] irq_mask_next;
    logic busy_d_reg;
    rsm_state_t state_reg, state_next;
    logic [3:0] cnt_reg;
    logic proc_hold_reg, periph_hold_reg, pin_req_reg;

    axil_port u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_hit),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // Pin sampling and drive, same slow clock as everything else
    pin_manager #(
        .LEN_WIDTH(LEN_W)
    ) u_pin (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pin_in),
        .drive_req(pin_req_reg),
        .len(mode_reg[MODE_LEN_LSB +: LEN_W]),
        .pin_level(pin_level),
        .pin_fall(pin_fall),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .busy(pin_busy)
    );

    // Address decode
    wire wr_mode = wr_en && (wr_addr == MODE_OFFSET);
    wire wr_ctrl = wr_en && (wr_addr == CTRL_OFFSET) && wr_strb[0];
    wire wr_istat = wr_en && (wr_addr == IRQ_STATUS_OFFSET) && wr_strb[0];
    wire wr_imask = wr_en && (wr_addr == IRQ_MASK_OFFSET);
    wire rd_status = rd_en && (rd_addr == STATUS_OFFSET);
    wire wr_status = (wr_addr == STATUS_OFFSET);
    assign wr_hit = (wr_addr == MODE_OFFSET) || wr_status || (wr_addr == CTRL_OFFSET)
        || (wr_addr == IRQ_STATUS_OFFSET) || (wr_addr == IRQ_MASK_OFFSET);
    assign rd_hit = (rd_addr == MODE_OFFSET) || (rd_addr == STATUS_OFFSET)
        || (rd_addr == CTRL_OFFSET) || (rd_addr == IRQ_STATUS_OFFSET)
        || (rd_addr == IRQ_MASK_OFFSET);

    // Mode fields
    wire urst_en = mode_reg[MODE_URST_EN_BIT];
    wire urst_irq_en = mode_reg[MODE_URST_IRQ_BIT];

    // Status word
    wire [31:0] status_word = {14'h0000, pin_busy, pin_level, 6'h00, cause_reg,
                               7'h00, seen_reg};

    // Read data mux
    assign rd_data = (rd_addr == MODE_OFFSET) ? mode_reg :
                     (rd_addr == STATUS_OFFSET) ? status_word :
                     (rd_addr == IRQ_STATUS_OFFSET) ? {30'h0000_0000, irq_stat_reg} :
                     (rd_addr == IRQ_MASK_OFFSET) ? {30'h0000_0000, irq_mask_reg} :
                     32'h0000_0000;

    // Software request bits
    wire soft_proc = wr_ctrl && wr_data[CTRL_PROC_BIT];
    wire soft_periph = wr_ctrl && wr_data[CTRL_PERIPH_BIT];
    wire soft_pin = wr_ctrl && wr_data[CTRL_PIN_BIT];
    wire soft_any = soft_proc || soft_periph || soft_pin;

    // Reset sources seen while idle
    wire idle = (state_reg == ST_IDLE);
    wire user_trig = pin_fall && urst_en && !urst_irq_en;
    wire user_irq_ev = idle && pin_fall && urst_irq_en;
    wire done_ev = busy_d_reg && !pin_busy;
    wire start = idle && (periph_reset_req || user_trig || soft_any);

    // Register next values
    assign mode_next = wr_mode ? merge(mode_reg, wr_data, wr_strb, MODE_WMASK) : mode_reg;
    assign seen_next = pin_fall || (seen_reg && !rd_status);
    assign irq_mask_next = wr_imask ?
        merge({30'h0000_0000, irq_mask_reg}, wr_data, wr_strb, 32'h0000_0003) :
        {30'h0000_0000, irq_mask_reg};
    assign irq_stat_next = ({done_ev, user_irq_ev})
        | (irq_stat_reg & ~(wr_istat ? wr_data[IRQ_W-1:0] : 2'h0));

    // Mode register is only reset, to MODE_RESET, by the io supply power-on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Status, interrupt and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_reg <= 1'b0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            busy_d_reg <= 1'b0;
        end else begin
            seen_reg <= seen_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next[IRQ_W-1:0];
            busy_d_reg <= pin_busy;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Reset state manager next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_reg == 4'h1) begin
                    state_next = ST_PIN_WAIT;
                end
            end
            ST_PIN_WAIT: begin
                if (!pin_busy && !pin_req_reg) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (cnt_reg == 4'h1 && pin_level) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Which outputs a new request asserts
    wire new_proc = periph_reset_req || user_trig || soft_proc;
    wire new_periph = periph_reset_req || user_trig || soft_periph;
    wire new_pin = periph_reset_req || (!user_trig && soft_pin);
    wire [1:0] new_cause = periph_reset_req ? CAUSE_PERIPH :
                           user_trig ? CAUSE_USER : CAUSE_SOFT;

    // State register, hold counter and reset output flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            proc_hold_reg <= 1'b0;
            periph_hold_reg <= 1'b0;
            pin_req_reg <= 1'b0;
            cause_reg <= CAUSE_NONE;
        end else begin
            state_reg <= state_next;
            pin_req_reg <= 1'b0;
            if (start) begin
                cnt_reg <= RESET_HOLD_CYC;
                proc_hold_reg <= new_proc;
                periph_hold_reg <= new_periph;
                pin_req_reg <= new_pin;
                cause_reg <= new_cause;
            end else if (state_reg == ST_HOLD) begin
                cnt_reg <= (cnt_reg == 4'h1) ? SETTLE_CYC : cnt_reg - 4'h1;
            end else if (state_reg == ST_RELEASE) begin
                // Wait for a settled high pin so our own drive is not seen as a user reset
                if (!pin_level || pin_busy) begin
                    cnt_reg <= SETTLE_CYC;
                end else if (cnt_reg != 4'h1) begin
                    cnt_reg <= cnt_reg - 4'h1;
                end else begin
                    proc_hold_reg <= 1'b0;
                    periph_hold_reg <= 1'b0;
                end
            end
        end
    end

    assign proc_resetn = !proc_hold_reg;
    assign periph_resetn = !periph_hold_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_seen_set;
        pin_fall |=> seen_reg;
    endproperty
    a_seen_set: assert property (p_seen_set) else $error("flag not set");

    property p_seen_read_clear;
        seen_reg && rd_status && !pin_fall |=> !seen_reg;
    endproperty
    a_seen_read_clear: assert property (p_seen_read_clear)
        else $error("flag not cleared by read");

    property p_seen_hold;
        seen_reg && !rd_status |=> seen_reg;
    endproperty
    a_seen_hold: assert property (p_seen_hold) else $error("flag lost");

    property p_level_read;
        rd_status |=> rvalid && rdata[STAT_LEVEL_BIT] == $past(pin_level);
    endproperty
    a_level_read: assert property (p_level_read) else $error("bad level");

    property p_user_reset;
        idle && pin_fall && urst_en && !urst_irq_en |=> !proc_resetn && !periph_resetn;
    endproperty
    a_user_reset: assert property (p_user_reset) else $error("no user reset");

    property p_disabled;
        idle && pin_fall && !urst_en && !periph_reset_req && !soft_any |=> proc_resetn;
    endproperty
    a_disabled: assert property (p_disabled) else $error("reset while off");

    property p_irq_instead;
        idle && pin_fall && urst_irq_en && !periph_reset_req && !soft_any
            |=> irq_stat_reg[IRQ_USER_BIT] && proc_resetn;
    endproperty
    a_irq_instead: assert property (p_irq_instead) else $error("no irq");

    property p_periph_src;
        idle && periph_reset_req |=> !proc_resetn && !periph_resetn ##1 pin_oe;
    endproperty
    a_periph_src: assert property (p_periph_src) else $error("no reset");

    property p_hold_len;
        $fell(proc_resetn) |-> !proc_resetn [*3];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("short reset");

    // Length of the current pin drive, so the upper bound needs no long delay range
    localparam int RUN_W = (1 << LEN_W) + 1;
    localparam logic [RUN_W-1:0] OE_RUN_MAX = RUN_W'(1) << (1 << LEN_W);
    logic [RUN_W-1:0] oe_run_reg;

    // Cycles with the pin driven so far, cleared while released
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_run_reg <= '0;
        end else if (pin_oe) begin
            oe_run_reg <= oe_run_reg + RUN_W'(1);
        end else begin
            oe_run_reg <= '0;
        end
    end

    property p_pin_min;
        $rose(pin_oe) |-> pin_oe [*2];
    endproperty
    a_pin_min: assert property (p_pin_min) else $error("short pin pulse");

    property p_pin_max;
        pin_oe |-> oe_run_reg < OE_RUN_MAX;
    endproperty
    a_pin_max: assert property (p_pin_max) else $error("long pin pulse");
endmodule // reset_controller

// [verilog/reset_ctrl_pkg.sv]
// Purpose: Shared constants for the reset controller
// Assumes: 32-bit AXI4-Lite register bus, one slow clock
// Notes: Offsets are byte addresses
package reset_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
    localparam int MODE_URST_EN_BIT = 0;
    localparam int MODE_URST_IRQ_BIT = 4;
    localparam int MODE_LEN_LSB = 8;
    localparam int LEN_W = 4;
    localparam logic [31:0] MODE_WMASK = 32'h0000_0F11;
    localparam logic [31:0] MODE_RESET = 32'h0000_0001;
    localparam int STAT_SEEN_BIT = 0;
    localparam int STAT_CAUSE_LSB = 8;
    localparam int STAT_LEVEL_BIT = 16;
    localparam int STAT_BUSY_BIT = 17;
    localparam int CTRL_PROC_BIT = 0;
    localparam int CTRL_PERIPH_BIT = 2;
    localparam int CTRL_PIN_BIT = 3;
    localparam int IRQ_W = 2;
    localparam int IRQ_USER_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_PERIPH = 2'h1;
    localparam logic [1:0] CAUSE_USER = 2'h2;
    localparam logic [1:0] CAUSE_SOFT = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] RESET_HOLD_CYC = 4'h3;
    localparam logic [3:0] SETTLE_CYC = 4'h4;
    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_PIN_WAIT, ST_RELEASE} rsm_state_t;
endpackage
